/* include/prs_map.svh */
// Offsets, field positions, reset values and widths of the pointer/stack unit
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH

// Register indices; byte address on APB is four times the index
`define PRS_IDX_PTR_LO     8'h80
`define PRS_IDX_PTR_HI     8'h81
`define PRS_IDX_TBL_HI     8'h82
`define PRS_IDX_PTR2_LO    8'h83
`define PRS_IDX_PTR2_HI    8'h84
`define PRS_IDX_SIDX       8'hDF
`define PRS_IDX_STK_FIRST  8'hF0
`define PRS_IDX_STK_LAST   8'hFF
`define PRS_IDX_IMM_FIRST  8'h80
`define PRS_IDX_IMM_LAST   8'h87

// Stack index register layout
`define PRS_GIE_BIT        7
`define PRS_SIDX_MSB       2
`define PRS_SIDX_RST       3'h7
`define PRS_GIE_RST        1'h0

// Stack entry layout
`define PRS_PC_W           13
`define PRS_PC_HI_W        5
`define PRS_STK_DEPTH      8

// APB decode
`define PRS_APB_AW         12
`define PRS_APB_IDX_LSB    2
`define PRS_APB_IDX_MSB    9

`endif

/* include/prs_pkg.sv */
// Types shared by the pointer/stack unit
package prs_pkg;

	typedef enum logic [1:0]
	{
		PRS_TBL_IDLE = 2'b00,
		PRS_TBL_ADDR = 2'b01,
		PRS_TBL_DATA = 2'b10
	} prs_tbl_e;

	typedef logic [7:0][12:0] prs_ent_t;

	typedef struct packed
	{
		logic [7:0]  ptr_lo;
		logic [7:0]  ptr_hi;
		logic [7:0]  tbl_hi;
		logic [7:0]  ptr2_lo;
		logic [7:0]  ptr2_hi;
		logic        global_irq_enable;
		logic [2:0]  sidx;
		prs_tbl_e    tbl;
		logic        rom_en;
		logic        acc_ld;
		logic [7:0]  acc;
		logic [12:0] ret_pc;
		logic        ret_vld;
		logic [7:0]  crd;
		logic        crej;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} prs_state_s;

	typedef struct packed
	{
		prs_ent_t ent;
	} prs_stk_s;

endpackage

/* include/prs_stk_if.sv */
// Write port and contents of the return stack storage
`timescale 1ns/1ps
interface prs_stk_if;
	import prs_pkg::*;

	logic        we;
	logic [2:0]  widx;
	logic [1:0]  wmask;
	logic [12:0] wdata;
	prs_ent_t    ent;

	modport ctrl  (output we, widx, wmask, wdata, input ent);
	modport store (input we, widx, wmask, wdata, output ent);
endinterface

/* hdl/prs_stack_store.sv */
// Eight 13-bit return stack entries with byte-masked writes
`timescale 1ns/1ps
`include "prs_map.svh"
module prs_stack_store
	import prs_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	prs_stk_if.store   stk
);

	prs_stk_s q;
	prs_stk_s d;
	prs_ent_t nxt;

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < `PRS_STK_DEPTH; g = g + 1)
		begin : g_ent
			logic hit;
			assign hit = stk.we && (stk.widx == 3'(g));
			// Low byte and high five bits are written separately
			assign nxt[g][7:0] = (hit && stk.wmask[0]) ?
				stk.wdata[7:0] : q.ent[g][7:0];
			assign nxt[g][12:8] = (hit && stk.wmask[1]) ?
				stk.wdata[12:8] : q.ent[g][12:8];
		end
	endgenerate

	always_comb
	begin
		d     = q;
		d.ent = nxt;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign stk.ent = q.ent;

endmodule // prs_stack_store

/* hdl/prs_unit.sv */
// Working pointer registers, return stack control and APB register slave
//
// Operation
// - Pointer high/low registers at 81H, 80H
// - First indirect port addresses RAM bank:location
// - Second pointer high/low at 84H, 83H
// - Second indirect port addresses RAM bank:location
// - Table read uses second pointer as ROM address
// - Table read: high byte to 82H, low to accumulator
// - Immediate writes only into 80H to 87H
// - Direct moves between accumulator and bank 0
// - Eight-level stack pushed on call or interrupt
// - Stack index bits 2:0 at DFH, reset 111
// - Entries 13 bits, reset zero, at F0H-FFH
// - Push decrements index, pop increments it
// - Pop returns most recently pushed value
// - Interrupt exit and subroutine exit both pop
// - First push fills entry 0, leaves 110
// - Bit 7 of index register: global irq enable
// - Index and entries are software read/write
// - Program counter is 13 bits, 5+8
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "prs_map.svh"
module prs_unit
	import prs_pkg::*;
(
	input  wire logic                     CLK_I,
	input  wire logic                     RST_N_I,
	// APB register slave
	input  wire logic                     PSEL_I,
	input  wire logic                     PENABLE_I,
	input  wire logic                     PWRITE_I,
	input  wire logic [`PRS_APB_AW-1:0]   PADDR_I,
	input  wire logic [31:0]              PWDATA_I,
	output logic      [31:0]              PRDATA_O,
	output logic                          PREADY_O,
	output logic                          PSLVERR_O,
	// Core register access, bank 0 system area
	input  wire logic                     CORE_WE_I,
	input  wire logic                     CORE_RE_I,
	input  wire logic                     CORE_IMM_I,
	input  wire logic [7:0]               CORE_ADDR_I,
	input  wire logic [7:0]               CORE_WDATA_I,
	output logic      [7:0]               CORE_RDATA_O,
	output logic                          CORE_REJ_O,
	// Stack operations
	input  wire logic                     CALL_I,
	input  wire logic                     IRQ_ENTER_I,
	input  wire logic                     SUB_EXIT_I,
	input  wire logic                     IRQ_EXIT_I,
	input  wire logic [`PRS_PC_W-1:0]     PC_I,
	output logic      [`PRS_PC_W-1:0]     RET_PC_O,
	output logic                          RET_VALID_O,
	output logic                          IRQ_EN_O,
	// Indirect RAM addresses {bank, location}
	output logic      [15:0]              IND1_ADDR_O,
	output logic      [15:0]              IND2_ADDR_O,
	// ROM table read
	input  wire logic                     TBL_REQ_I,
	output logic                          ROM_EN_O,
	output logic      [15:0]              ROM_ADDR_O,
	input  wire logic [15:0]              ROM_DATA_I,
	output logic                          ACC_LOAD_O,
	output logic      [7:0]               ACC_DATA_O
);

	prs_state_s q;
	prs_state_s d;
	prs_stk_if  stk ();

	logic       apb_setup;
	logic       apb_wr;
	logic       apb_hit;
	logic [7:0] apb_idx;
	logic       push;
	logic       pop;
	logic       core_ok;
	logic [2:0] push_slot;
	logic [2:0] pop_slot;

	////////////////////////////////////////////////////////////////////////
	// Storage of the stack entries
	// Its single write port is shared; this module settles priority.

	prs_stack_store prs_stack_store_i
	(
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.stk     (stk.store)
	);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	//
	// Bank-0 system map, shared by the core port and APB:
	//   80H..84H  pointer bytes and the table high byte
	//   DFH       {irq enable, 0000, stack index}
	//   F0H..FFH  stack bytes, entry n low at FEH-2n, high at FFH-2n
	// Any other index reads zero; on APB it also answers an error.

	function automatic logic is_stk(input logic [7:0] a);
		is_stk = (a >= `PRS_IDX_STK_FIRST) && (a <= `PRS_IDX_STK_LAST);
	endfunction

	// Entry n low byte sits at FEH-2n, high byte at FFH-2n
	function automatic logic [2:0] stk_entry(input logic [7:0] a);
		stk_entry = ~a[3:1];
	endfunction

	// Indices this block answers for, on either port
	function automatic logic hit(input logic [7:0] a);
		hit = (a >= `PRS_IDX_PTR_LO && a <= `PRS_IDX_PTR2_HI) ||
			(a == `PRS_IDX_SIDX) || is_stk(a);
	endfunction

	function automatic logic [7:0] rd(input prs_state_s s,
		input prs_ent_t e, input logic [7:0] a);
		logic [12:0] v;
		v  = e[stk_entry(a)];
		rd = 8'h00;
		case (a)
			`PRS_IDX_PTR_LO:  rd = s.ptr_lo;
			`PRS_IDX_PTR_HI:  rd = s.ptr_hi;
			`PRS_IDX_TBL_HI:  rd = s.tbl_hi;
			`PRS_IDX_PTR2_LO: rd = s.ptr2_lo;
			`PRS_IDX_PTR2_HI: rd = s.ptr2_hi;
			`PRS_IDX_SIDX:    rd = {s.global_irq_enable, 4'h0, s.sidx};
			default:
			begin
				// Unused bits 7:5 of a high byte read as zero
				if (is_stk(a))
					rd = a[0] ? {3'h0, v[12:8]} : v[7:0];
			end
		endcase
	endfunction

	function automatic prs_state_s put(input prs_state_s s,
		input logic [7:0] a, input logic [7:0] v);
		put = s;
		case (a)
			`PRS_IDX_PTR_LO:  put.ptr_lo  = v;
			`PRS_IDX_PTR_HI:  put.ptr_hi  = v;
			`PRS_IDX_TBL_HI:  put.tbl_hi  = v;
			`PRS_IDX_PTR2_LO: put.ptr2_lo = v;
			`PRS_IDX_PTR2_HI: put.ptr2_hi = v;
			`PRS_IDX_SIDX:
			begin
				// Bits 6:3 are not stored and read back as zero
				put.global_irq_enable  = v[`PRS_GIE_BIT];
				put.sidx = v[`PRS_SIDX_MSB:0];
			end
			default:
			begin
				// Stack bytes are not held here; the caller routes
				// them to the storage write port instead.
				put = s;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB decode

	// Byte offsets inside a word and bits above the index are refused,
	// so a mistyped address can never alias onto a live register.
	assign apb_idx   = PADDR_I[`PRS_APB_IDX_MSB:`PRS_APB_IDX_LSB];
	assign apb_hit   = (PADDR_I[`PRS_APB_AW-1:`PRS_APB_IDX_MSB+1] == '0) &&
		(PADDR_I[1:0] == 2'h0) && hit(apb_idx);
	assign apb_setup = PSEL_I && !PENABLE_I;
	// The answer is prepared in the setup cycle, so every access phase
	// completes on its first edge and no wait state is ever inserted.
	// Writes land only at the edge that completes the access phase
	assign apb_wr    = PSEL_I && PENABLE_I && PWRITE_I && q.pready &&
		!q.pslverr;

	assign push    = CALL_I || IRQ_ENTER_I;
	assign pop     = SUB_EXIT_I || IRQ_EXIT_I;
	// The index names the next free slot counted from the top: 111 is
	// empty, or full after eight pushes. A push writes the slot given
	// by the inverted index; a pop reads the slot one above the index,
	// which is the one its matching push wrote. Software may rewrite
	// the index at any time and nothing checks it against the depth.
	assign push_slot = ~q.sidx;
	assign pop_slot  = ~(q.sidx + 3'h1);
	// Immediate operands may only target the working register window
	assign core_ok = !CORE_IMM_I ||
		((CORE_ADDR_I >= `PRS_IDX_IMM_FIRST) &&
		(CORE_ADDR_I <= `PRS_IDX_IMM_LAST));

	////////////////////////////////////////////////////////////////////////
	// Next state
	//
	// Write priority, lowest first: APB, core port, stack sequencer,
	// table load. Each stage overwrites what the one before it put into
	// the next-state copy, so the order of the blocks is the priority.

	always_comb
	begin
		// Pulses and the storage write port default to idle each cycle
		d         = q;
		d.pready  = 1'b0;
		d.pslverr = 1'b0;
		d.rom_en  = 1'b0;
		d.acc_ld  = 1'b0;
		d.ret_vld = 1'b0;
		d.crej    = 1'b0;
		stk.we    = 1'b0;
		stk.widx  = 3'h0;
		stk.wmask = 2'h0;
		stk.wdata = '0;

		// No wait state: answer is prepared in the setup cycle
		if (apb_setup)
		begin
			d.pready  = 1'b1;
			d.pslverr = !apb_hit;
			d.prdata  = apb_hit ? {24'h0, rd(q, stk.ent, apb_idx)} : 32'h0;
		end

		// Lowest priority: software over APB
		if (apb_wr)
		begin
			d = put(d, apb_idx, PWDATA_I[7:0]);
			if (is_stk(apb_idx))
			begin
				stk.we    = 1'b1;
				stk.widx  = stk_entry(apb_idx);
				stk.wmask = apb_idx[0] ? 2'b10 : 2'b01;
				stk.wdata = {PWDATA_I[4:0], PWDATA_I[7:0]};
			end
		end

		// Core moves always address bank 0 and beat a same-cycle APB write
		// A read and a write of one byte in one cycle return the old
		// contents; read data then holds until the next read.
		if (CORE_RE_I)
			d.crd = rd(q, stk.ent, CORE_ADDR_I);
		if (CORE_WE_I && !core_ok)
			d.crej = 1'b1;
		if (CORE_WE_I && core_ok)
		begin
			d = put(d, CORE_ADDR_I, CORE_WDATA_I);
			if (is_stk(CORE_ADDR_I))
			begin
				stk.we    = 1'b1;
				stk.widx  = stk_entry(CORE_ADDR_I);
				stk.wmask = CORE_ADDR_I[0] ? 2'b10 : 2'b01;
				stk.wdata = {CORE_WDATA_I[4:0], CORE_WDATA_I};
			end
		end

		// Stack traffic from the sequencer beats any software access;
		// a push and a pop together count as a push.
		if (push)
		begin
			// Index 111 stores entry 0, index 000 stores entry 7
			stk.we    = 1'b1;
			stk.widx  = push_slot;
			stk.wmask = 2'b11;
			stk.wdata = PC_I;
			// Ninth push wraps and overwrites, nothing flags it
			d.sidx    = q.sidx - 3'h1;
		end
		else if (pop)
		begin
			d.sidx    = q.sidx + 3'h1;
			d.ret_pc  = stk.ent[pop_slot];
			d.ret_vld = 1'b1;
		end

		// ROM table read: address phase, then capture the word
		// The ROM sees the address in the cycle after the request and
		// must show the word one cycle later; a request made while a
		// read is under way is dropped, not queued.
		case (q.tbl)
			PRS_TBL_IDLE:
			begin
				if (TBL_REQ_I)
				begin
					d.tbl    = PRS_TBL_ADDR;
					d.rom_en = 1'b1;
				end
			end
			PRS_TBL_ADDR:
			begin
				// Address is on the ROM port; wait for its word
				d.tbl = PRS_TBL_DATA;
			end
			PRS_TBL_DATA:
			begin
				// Hardware load wins over a software write the same cycle
				d.tbl_hi = ROM_DATA_I[15:8];
				d.acc    = ROM_DATA_I[7:0];
				d.acc_ld = 1'b1;
				d.tbl    = PRS_TBL_IDLE;
			end
			default:
			begin
				d.tbl = PRS_TBL_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			// Pointers power up undefined; zero keeps simulation clean
			// and costs nothing, since software must load them anyway.
			q      <= '0;
			q.sidx <= `PRS_SIDX_RST;
			q.global_irq_enable  <= `PRS_GIE_RST;
			q.tbl  <= PRS_TBL_IDLE;
		end
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	//
	// Every output is a bit of the state register, so no port has a
	// combinational path from any input.

	assign PRDATA_O     = q.prdata;
	assign PREADY_O     = q.pready;
	assign PSLVERR_O    = q.pslverr;
	assign CORE_RDATA_O = q.crd;
	assign CORE_REJ_O   = q.crej;
	assign RET_PC_O     = q.ret_pc;
	assign RET_VALID_O  = q.ret_vld;
	assign IRQ_EN_O     = q.global_irq_enable;
	assign IND1_ADDR_O  = {q.ptr_hi, q.ptr_lo};
	assign IND2_ADDR_O  = {q.ptr2_hi, q.ptr2_lo};
	assign ROM_EN_O     = q.rom_en;
	// Taken straight from the second pointer; nothing holds it during a read
	assign ROM_ADDR_O   = {q.ptr2_hi, q.ptr2_lo};
	assign ACC_LOAD_O   = q.acc_ld;
	assign ACC_DATA_O   = q.acc;

endmodule // prs_unit

/* test/prs_unit_props.sv */
// Concurrent checks on the pointer and stack unit ports
`timescale 1ns/1ps
module prs_unit_props
(
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PREADY_O,
	input wire logic        CALL_I,
	input wire logic        IRQ_ENTER_I,
	input wire logic        SUB_EXIT_I,
	input wire logic        IRQ_EXIT_I,
	input wire logic        RET_VALID_O,
	input wire logic        ROM_EN_O,
	input wire logic        ACC_LOAD_O,
	input wire logic        CORE_REJ_O,
	input wire logic        CORE_WE_I,
	input wire logic        CORE_IMM_I,
	input wire logic [7:0]  CORE_ADDR_I,
	input wire logic [7:0]  CORE_WDATA_I,
	input wire logic [12:0] PC_I,
	input wire logic [12:0] RET_PC_O,
	input wire logic [15:0] ROM_ADDR_O,
	input wire logic [15:0] IND1_ADDR_O,
	input wire logic [15:0] IND2_ADDR_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic push;
	logic pop;
	logic imm_out;
	// A push in the same cycle wins, so it is not a pop
	assign push = CALL_I | IRQ_ENTER_I;
	assign pop = !push & (SUB_EXIT_I | IRQ_EXIT_I);
	assign imm_out = CORE_WE_I & CORE_IMM_I & (CORE_ADDR_I[7:3] != 5'h10);
	pop_ret_a: assert property (pop |=> RET_VALID_O)
		else $error("pop gave no return pulse");
	lifo_ret_a: assert property (push ##1 pop
		|=> RET_PC_O == $past(PC_I, 2))
		else $error("pop did not return last push");
	tbl_load_a: assert property ($rose(ROM_EN_O) |-> ##2 ACC_LOAD_O)
		else $error("table load late");
	rom_ptr_a: assert property (ROM_EN_O |-> ROM_ADDR_O == IND2_ADDR_O)
		else $error("rom address not second pointer");
	apb_ready_a: assert property (PSEL_I & !PENABLE_I |=> PREADY_O)
		else $error("register access not answered");
	imm_rej_a: assert property (imm_out |=> CORE_REJ_O)
		else $error("immediate write outside range taken");
	imm_ok_a: assert property (CORE_WE_I & !imm_out |=> !CORE_REJ_O)
		else $error("legal write refused");
	ptr_hi_a: assert property (CORE_WE_I & CORE_ADDR_I == 8'h81
		|=> IND1_ADDR_O[15:8] == $past(CORE_WDATA_I))
		else $error("bank byte not on first port");
endmodule // prs_unit_props
bind prs_unit prs_unit_props prs_unit_props_i
(
	.CLK_I        (CLK_I),
	.RST_N_I      (RST_N_I),
	.PSEL_I       (PSEL_I),
	.PENABLE_I    (PENABLE_I),
	.PREADY_O     (PREADY_O),
	.CALL_I       (CALL_I),
	.IRQ_ENTER_I  (IRQ_ENTER_I),
	.SUB_EXIT_I   (SUB_EXIT_I),
	.IRQ_EXIT_I   (IRQ_EXIT_I),
	.RET_VALID_O  (RET_VALID_O),
	.ROM_EN_O     (ROM_EN_O),
	.ACC_LOAD_O   (ACC_LOAD_O),
	.CORE_REJ_O   (CORE_REJ_O),
	.CORE_WE_I    (CORE_WE_I),
	.CORE_IMM_I   (CORE_IMM_I),
	.CORE_ADDR_I  (CORE_ADDR_I),
	.CORE_WDATA_I (CORE_WDATA_I),
	.PC_I         (PC_I),
	.RET_PC_O     (RET_PC_O),
	.ROM_ADDR_O   (ROM_ADDR_O),
	.IND1_ADDR_O  (IND1_ADDR_O),
	.IND2_ADDR_O  (IND2_ADDR_O)
);

/* test/prs_rom_model.sv */
// Program ROM model answering table reads
`timescale 1ns/1ps
module prs_rom_model
(
	input  wire logic        clk_i,
	input  wire logic        rom_en_i,
	input  wire logic [15:0] rom_addr_i,
	output logic      [15:0] rom_data_o
);
	initial rom_data_o = 16'h0000;
	// Word valid only in the cycle after the enable; it flips otherwise
	// so a sample on the wrong edge shows as a wrong byte
	always @(posedge clk_i)
		rom_data_o <= rom_en_i ? (rom_addr_i ^ 16'h5AC3) : ~rom_data_o;
endmodule // prs_rom_model

/* test/prs_unit_tb_top.sv */
// Self-checking bench for the pointer and stack unit
`timescale 1ns/1ps
module prs_unit_tb_top;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic        we = 0, re = 0, imm = 0, tbl = 0;
	logic        call = 0, irqe = 0, sube = 0, irqx = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [7:0]  caddr = 0, cwd = 0;
	logic [12:0] pc = 0;
	wire  [31:0] prdata;
	wire  [15:0] ind1, ind2, rom_addr, rom_data;
	wire  [12:0] ret_pc;
	wire  [7:0]  crd, acc;
	wire         pready, pslverr, rej, ret_v, irq_en, rom_en, acc_ld;
	int          n_mismatch = 0, checks = 0, cyc = 0;
	prs_unit prs_unit_i (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.CORE_WE_I(we), .CORE_RE_I(re), .CORE_IMM_I(imm),
		.CORE_ADDR_I(caddr), .CORE_WDATA_I(cwd), .CORE_RDATA_O(crd),
		.CORE_REJ_O(rej), .CALL_I(call), .IRQ_ENTER_I(irqe),
		.SUB_EXIT_I(sube), .IRQ_EXIT_I(irqx), .PC_I(pc), .RET_PC_O(ret_pc),
		.RET_VALID_O(ret_v), .IRQ_EN_O(irq_en), .IND1_ADDR_O(ind1),
		.IND2_ADDR_O(ind2), .TBL_REQ_I(tbl), .ROM_EN_O(rom_en),
		.ROM_ADDR_O(rom_addr), .ROM_DATA_I(rom_data), .ACC_LOAD_O(acc_ld),
		.ACC_DATA_O(acc));
	prs_rom_model prs_rom_model_i (.clk_i(clk), .rom_en_i(rom_en),
		.rom_addr_i(rom_addr), .rom_data_o(rom_data));
	initial
		forever #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i,
		input logic [31:0] d, input logic e);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		chk(pslverr, e);
		psel <= 0;
		pen <= 0;
	endtask
	task automatic rdc(input logic [7:0] i, input logic [31:0] x);
		apb(0, i, 0, 0);
		chk(rd, x);
	endtask
	// Push when p is set, else pop; k picks the interrupt flavour
	task automatic stk(input logic k, p, input logic [12:0] v);
		@(posedge clk);
		call <= p & !k;
		irqe <= p & k;
		sube <= !p & !k;
		irqx <= !p & k;
		pc <= v;
		@(posedge clk);
		{call, irqe, sube, irqx} <= 4'h0;
		#1;
		if (!p)
			chk({ret_v, ret_pc}, {1'b1, v});
	endtask
	task automatic cw(input logic m, input logic [7:0] a, d, input logic r);
		@(posedge clk);
		we <= 1;
		imm <= m;
		caddr <= a;
		cwd <= d;
		@(posedge clk);
		we <= 0;
		#1;
		chk(rej, r);
	endtask
	function automatic logic [12:0] pv(int n);
		return 13'h0ABC + 13'(n * 'h111);
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc(8'hDF, 32'h07);
		chk(irq_en, 0);
		for (int n = 0; n < 16; n++)
			rdc(8'hF0 + 8'(n), 0);
		$display("reset test done");
	endtask
	task automatic t_regs;
		for (int n = 0; n < 5; n++)
			apb(1, 8'h80 + 8'(n), 32'h5A ^ n, 0);
		for (int n = 0; n < 5; n++)
			rdc(8'h80 + 8'(n), 32'h5A ^ n);
		chk(ind1, 16'h5B5A);
		chk(ind2, 16'h5E59);
		apb(1, 8'h85, 32'hFF, 1);
		chk(rd, 0);
		apb(1, 8'hDF, 32'h85, 0);
		rdc(8'hDF, 32'h85);
		chk(irq_en, 1);
		apb(1, 8'hDF, 32'h07, 0);
		apb(1, 8'hFF, 32'hFF, 0);
		rdc(8'hFF, 32'h1F);
		$display("register test done");
	endtask
	task automatic t_stack;
		apb(1, 8'hDF, 32'h07, 0);
		for (int n = 0; n < 8; n++)
		begin
			stk(n[0], 1, pv(n));
			if (n == 0)
				rdc(8'hDF, 32'h06);
		end
		rdc(8'hDF, 32'h07);
		rdc(8'hFE, 32'hBC);
		rdc(8'hF1, 32'h12);
		for (int n = 7; n >= 0; n--)
			stk(n[0], 0, pv(n));
		rdc(8'hDF, 32'h07);
		for (int n = 0; n < 9; n++)
			stk(n[0], 1, pv(n));
		rdc(8'hDF, 32'h06);
		rdc(8'hFE, 32'h44);
		apb(1, 8'hDF, 32'h07, 0);
		@(posedge clk);
		irqe <= 1;
		pc <= 13'h1555;
		@(posedge clk);
		irqe <= 0;
		irqx <= 1;
		@(posedge clk);
		irqx <= 0;
		#1;
		chk({ret_v, ret_pc}, {1'b1, 13'h1555});
		$display("stack test done");
	endtask
	task automatic t_table;
		cw(1, 8'h84, 8'h12, 0);
		cw(1, 8'h83, 8'h34, 0);
		@(posedge clk);
		tbl <= 1;
		@(posedge clk);
		tbl <= 0;
		repeat (2) @(posedge clk);
		#1;
		chk({acc_ld, acc}, {1'b1, 8'hF7});
		rdc(8'h82, 32'h48);
		cw(1, 8'h90, 8'h11, 1);
		cw(0, 8'h90, 8'h11, 0);
		cw(0, 8'h81, 8'hA5, 0);
		chk(ind1, 16'hA55A);
		@(posedge clk);
		re <= 1;
		caddr <= 8'h83;
		@(posedge clk);
		re <= 0;
		#1;
		chk(crd, 8'h34);
		$display("table test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			end_sim;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_regs;
		t_stack;
		t_table;
		end_sim;
	end
endmodule // prs_unit_tb_top
